// ===== src/host_port_ready_handshake.v
`timescale 1ns/1ns
`include "host_port_map.vh"

// Functional notes
// - Strobe is XNOR of data strobes, OR select
// - Busy held low while chip select high
// - Busy high at select if work pending
// - First-half data read requests word, busy until loaded
// - Busy high after second half of a write or an auto read
// - Other accesses leave busy unchanged
// - Control and address accesses leave busy alone
// - Drive data bus only while strobe low
// - Data valid before busy falls, lead kept
module host_port_ready_handshake #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire SYS_CLK,
	input wire RST_B,
	// Host control pins
	input wire HOST_CHIP_SELECT_N,
	input wire DATA_STROBE_ONE_N,
	input wire DATA_STROBE_TWO_N,
	input wire HOST_READ_WRITE,
	input wire HALFWORD_SELECT,
	input wire [1:0] ACCESS_SELECT_FIELD,
	// Host data bus, split three ways
	input wire [WIDTH-1:0] HOST_DATA_IN,
	output reg [WIDTH-1:0] HOST_DATA_OUT,
	output reg HOST_DATA_OE,
	// Ready/busy toward host
	output reg HOST_BUSY_FLAG,
	// Auxiliary channel read request and answer
	output reg AUX_READ_REQ,
	input wire AUX_READ_DONE,
	input wire [2*WIDTH-1:0] AUX_READ_WORD,
	// Written words toward the auxiliary channel
	output reg AUX_WRITE_VALID,
	input wire AUX_WRITE_READY,
	output reg [2*WIDTH-1:0] AUX_WRITE_WORD
);
	// Two-stage synchronisers for control pins
	reg [6:0] sync_a; // First stage, read only by second stage
	reg [6:0] sync_b; // Second stage, safe to use
	wire cs_n = sync_b[0];
	wire ds1_n = sync_b[1];
	wire ds2_n = sync_b[2];
	wire rnw = sync_b[3];
	wire half2 = sync_b[4];
	wire [1:0] sel = sync_b[6:5];
	wire strobe_n; // Combined host strobe, active low
	reg strobe_q; // Previous strobe value
	wire strobe_fall;
	wire strobe_rise;

	// Internal work state
	localparam ST_IDLE = 2'h0;
	localparam ST_FETCH = 2'h1; // Waiting for auxiliary read word
	localparam ST_LEAD = 2'h2; // Data on bus, holding busy for lead
	reg [1:0] state;
	reg pending; // Earlier transfer still being completed
	reg [2*WIDTH-1:0] data_word; // Data register contents
	reg [WIDTH-1:0] low_half; // First half of a write
	reg [1:0] lead_cnt; // Lead counter
	reg fifo_valid;
	wire fifo_ready;
	wire out_valid;
	wire [2*WIDTH-1:0] out_data;

	// True for data register selects, decoded in several places
	function is_data;
		input [1:0] s;
		begin
			is_data = (s == `SEL_DATA_AUTO) || (s == `SEL_DATA_FIXED);
		end
	endfunction

	assign strobe_n = ~(ds1_n ^ ds2_n) | cs_n;
	assign strobe_fall = strobe_q & ~strobe_n;
	assign strobe_rise = ~strobe_q & strobe_n;

	// Synchronise asynchronous host pins
	always @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync_a <= 7'h7f;
			sync_b <= 7'h7f;
			strobe_q <= 1'b1;
		end else begin
			sync_a <= {ACCESS_SELECT_FIELD, HALFWORD_SELECT, HOST_READ_WRITE,
				DATA_STROBE_TWO_N, DATA_STROBE_ONE_N, HOST_CHIP_SELECT_N};
			sync_b <= sync_a;
			strobe_q <= strobe_n;
		end
	end

	// Main handshake; host is relied on to wait for busy low and
	// keep four-period strobe widths so no edge is missed here
	always @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			pending <= 1'b0;
			data_word <= {(2*WIDTH){1'b0}};
			low_half <= {WIDTH{1'b0}};
			lead_cnt <= 2'h0;
			fifo_valid <= 1'b0;
			AUX_READ_REQ <= 1'b0;
			HOST_BUSY_FLAG <= `BUSY_RESET;
			HOST_DATA_OUT <= {WIDTH{1'b0}};
			HOST_DATA_OE <= 1'b0;
		end else begin
			AUX_READ_REQ <= 1'b0;
			if (fifo_valid && fifo_ready) begin
				fifo_valid <= 1'b0;
				pending <= 1'b0;
			end
			// Drive bus while strobe low on reads, release on rise
			if (strobe_rise || cs_n) begin
				HOST_DATA_OE <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					if (strobe_fall && rnw && is_data(sel) && !half2 && !pending) begin
						AUX_READ_REQ <= 1'b1;
						state <= ST_FETCH;
					end else if (strobe_fall && rnw) begin
						// Control, address, second half or read while pending: data straight out
						HOST_DATA_OUT <= (sel == `SEL_CONTROL || sel == `SEL_ADDRESS) ?
							{WIDTH{1'b0}} : (half2 ? data_word[2*WIDTH-1:WIDTH] :
							data_word[WIDTH-1:0]);
						HOST_DATA_OE <= 1'b1;
					end
					if (strobe_fall && !rnw && is_data(sel) && !half2) begin
						low_half <= HOST_DATA_IN;
					end
					// Second half rising edge of a write or auto read starts internal completion
					if (strobe_rise && is_data(sel) && half2) begin
						if (!rnw) begin
							data_word <= {HOST_DATA_IN, low_half};
							fifo_valid <= 1'b1;
							pending <= 1'b1;
						end else if (sel == `SEL_DATA_AUTO) begin
							AUX_READ_REQ <= 1'b1;
							pending <= 1'b1;
						end
					end
				end
				ST_FETCH: begin
					if (AUX_READ_DONE) begin
						data_word <= AUX_READ_WORD;
						HOST_DATA_OUT <= AUX_READ_WORD[WIDTH-1:0];
						HOST_DATA_OE <= 1'b1;
						lead_cnt <= 2'h0;
						state <= ST_LEAD;
					end
				end
				ST_LEAD: begin
					lead_cnt <= lead_cnt + 2'h1;
					if (lead_cnt == `DATA_LEAD_CYC - 1) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			// Prefetch for auto read finishes completion
			if (state == ST_IDLE && pending && rnw && AUX_READ_DONE) begin
				data_word <= AUX_READ_WORD;
				pending <= 1'b0;
			end
			// Busy output; control and address accesses add no term
			if (cs_n) begin
				HOST_BUSY_FLAG <= 1'b0;
			end else if (state != ST_IDLE) begin
				HOST_BUSY_FLAG <= 1'b1;
			end else if (strobe_fall && rnw && is_data(sel) && !half2 && !pending) begin
				HOST_BUSY_FLAG <= 1'b1;
			end else begin
				HOST_BUSY_FLAG <= pending;
			end
		end
	end

	// Written words leave through the FIFO
	word_fifo #(.WIDTH(2*WIDTH), .DEPTH(DEPTH), .AW(AW)) write_fifo (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.in_valid(fifo_valid),
		.in_ready(fifo_ready),
		.in_data(data_word),
		.out_valid(out_valid),
		.out_ready(AUX_WRITE_READY | ~AUX_WRITE_VALID),
		.out_data(out_data)
	);

	// Register the FIFO output so the port comes from a flip-flop
	always @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			AUX_WRITE_VALID <= 1'b0;
			AUX_WRITE_WORD <= {(2*WIDTH){1'b0}};
		end else if (AUX_WRITE_READY | ~AUX_WRITE_VALID) begin
			AUX_WRITE_VALID <= out_valid;
			AUX_WRITE_WORD <= out_data;
		end
	end
endmodule

// ===== src/host_port_map.vh
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH
// Access select field encodings (two bits)
`define SEL_CONTROL 2'h0
`define SEL_DATA_AUTO 2'h1
`define SEL_ADDRESS 2'h2
`define SEL_DATA_FIXED 2'h3
// Clock period in ns (20 MHz)
`define CLK_PERIOD_NS 50
// Least lead of data before ready, in ns: two periods less six
`define DATA_LEAD_NS ((2 * `CLK_PERIOD_NS) - 6)
// Lead in cycles, rounded up, at least one
`define DATA_LEAD_CYC ((`DATA_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least strobe low and high width, in clock periods
`define STROBE_MIN_PERIODS 4
// Reset value of the busy line
`define BUSY_RESET 1'b0
`endif

// ===== src/word_fifo.v
`timescale 1ns/1ns
// Small synchronous FIFO, valid and ready on both sides
module word_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
	reg [AW-1:0] wr_ptr; // Write index
	reg [AW-1:0] rd_ptr; // Read index
	reg [AW:0] count; // Words held
	wire push;
	wire pop;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage write, no reset needed for data
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and occupancy
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ===== tb/host_port_ready_handshake_monitor.sv
`timescale 1ns/1ns
module host_port_ready_handshake_monitor (
	// Clock and reset
	input wire SYS_CLK,
	input wire RST_B,
	// Host pins and replies
	input wire HOST_CHIP_SELECT_N,
	input wire DATA_STROBE_ONE_N,
	input wire DATA_STROBE_TWO_N,
	input wire HOST_DATA_OE,
	input wire HOST_BUSY_FLAG,
	input wire AUX_READ_REQ,
	input wire AUX_WRITE_VALID,
	input wire AUX_WRITE_READY
);
	// Combined strobe, low during an access
	wire stb = ~(DATA_STROBE_ONE_N ^ DATA_STROBE_TWO_N) | HOST_CHIP_SELECT_N;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);
	// Four cycles leave room for the two-flop synchroniser
	cs_hides_oe_a: assert property (HOST_CHIP_SELECT_N [*4] |-> !HOST_DATA_OE)
		else $error("bus driven while deselected");
	cs_hides_busy_a: assert property (HOST_CHIP_SELECT_N [*4] |-> !HOST_BUSY_FLAG)
		else $error("busy while deselected");
	strobe_high_oe_a: assert property (stb [*4] |-> !HOST_DATA_OE)
		else $error("bus driven after strobe rise");
	req_sets_busy_a: assert property (AUX_READ_REQ && !stb |-> ##[0:1] HOST_BUSY_FLAG)
		else $error("request without busy");
	req_pulse_a: assert property (AUX_READ_REQ |=> !AUX_READ_REQ)
		else $error("request longer than one cycle");
	data_lead_a: assert property ($fell(HOST_BUSY_FLAG) && HOST_DATA_OE |-> $past(HOST_DATA_OE, 2))
		else $error("busy fell without data lead");
	edge_synced_a: assert property ($fell(stb) |=> !AUX_READ_REQ ##1 !AUX_READ_REQ)
		else $error("request before synchroniser");
	word_held_a: assert property (AUX_WRITE_VALID && !AUX_WRITE_READY |=> AUX_WRITE_VALID)
		else $error("written word dropped");
	cover property ($rose(HOST_BUSY_FLAG));
	cover property ($fell(HOST_BUSY_FLAG) && HOST_DATA_OE);
	cover property (AUX_WRITE_VALID && !AUX_WRITE_READY);
endmodule
bind host_port_ready_handshake host_port_ready_handshake_monitor u_host_port_ready_handshake_monitor (.*);

// ===== tb/aux_channel_model.sv
`timescale 1ns/1ns
// Auxiliary channel: loads a word five cycles after each request
module aux_channel_model (
	input wire clk,
	input wire req,
	output reg done,
	output reg [31:0] word
);
	reg [2:0] cnt = 3'h0; // Cycles left until load
	reg [31:0] nxt = 32'h5A5A_0001; // Next word handed out
	initial done = 1'b0;
	initial word = 32'h0000_0000;
	// Word lines toggle outside the answer so a stale value never passes
	always @(posedge clk) begin
		done <= (cnt == 3'h1);
		word <= (cnt == 3'h1) ? nxt : ~word;
		if (cnt == 3'h1)
			nxt <= nxt + 32'h0001_0001;
		cnt <= req ? 3'h5 : (cnt != 3'h0) ? cnt - 3'h1 : cnt;
	end
endmodule

// ===== tb/test_host_port_ready_handshake.sv
`timescale 1ns/1ns
`include "host_port_map.vh"
module test_host_port_ready_handshake;
	reg clk = 0, rst_b = 0, cs_n = 1, ds1_n = 1, rw = 0, hw = 0, stall = 0, saw = 0;
	reg ds2_n = 1, two = 0; // Second data strobe, and which strobe an access uses
	reg [1:0] sel = 2'h0;
	reg [15:0] din = 16'h0000, rdat;
	reg [31:0] lw = 32'h0000_0000; // Last word taken by the sink
	wire [15:0] dout;
	wire oe, busy, req, done, wv;
	wire [31:0] rword, wword;
	integer bad_count = 0, n_tests = 0;
	wire [15:0] hd = oe ? dout : din; // Bus level from both drivers
	always #25 clk = ~clk;
	// Sink takes written words unless stalled
	always @(posedge clk) if (wv && !stall) lw <= wword;
	host_port_ready_handshake u_host_port_ready_handshake (.SYS_CLK(clk), .RST_B(rst_b),
		.HOST_CHIP_SELECT_N(cs_n), .DATA_STROBE_ONE_N(ds1_n), .DATA_STROBE_TWO_N(ds2_n),
		.HOST_READ_WRITE(rw), .HALFWORD_SELECT(hw), .ACCESS_SELECT_FIELD(sel),
		.HOST_DATA_IN(hd), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
		.HOST_BUSY_FLAG(busy), .AUX_READ_REQ(req), .AUX_READ_DONE(done),
		.AUX_READ_WORD(rword), .AUX_WRITE_VALID(wv), .AUX_WRITE_READY(!stall),
		.AUX_WRITE_WORD(wword));
	aux_channel_model u_aux_channel_model (.clk(clk), .req(req), .done(done), .word(rword));
	task check(input [79:0] nm, input [31:0] exp, got);
		begin
			n_tests = n_tests + 1;
			if (exp !== got) begin
				bad_count = bad_count + 1;
				$display("Error %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// Keep the strobe state eight cycles, then until busy drops
	task hold;
		integer i;
		for (i = 0; i < 40 && (i < 8 || busy !== 1'b0); i = i + 1) begin
			@(negedge clk);
			saw = saw | (busy === 1'b1);
		end
	endtask
	// One half-word access, selects set a cycle ahead of the strobe
	task acc(input [1:0] s, input r, h, input [15:0] d);
		begin
			{sel, rw, hw, din, saw} = {s, r, h, d, 1'b0};
			@(negedge clk);
			if (two)
				ds2_n = 1'b0;
			else
				ds1_n = 1'b0;
			hold;
			// Bus level, so a read that is not driven shows the host's own value
			rdat = hd;
			{ds1_n, ds2_n} = 2'b11;
			hold;
		end
	endtask
	task t_idle;
		begin
			acc(`SEL_DATA_FIXED, 1'b1, 1'b0, 16'h0000);
			check("busy", 32'h0, saw);
		end
	endtask
	task t_regs;
		begin
			cs_n = 1'b0;
			acc(`SEL_CONTROL, 1'b0, 1'b0, 16'h00A5);
			check("busy", 32'h0, saw);
			two = 1'b1;
			acc(`SEL_ADDRESS, 1'b1, 1'b1, 16'hFFFF);
			check("busy", 32'h0, saw);
			check("addr read", 32'h0, rdat);
			two = 1'b0;
		end
	endtask
	// Auto-increment read; select dropped and raised while the prefetch runs
	task t_auto;
		begin
			acc(`SEL_DATA_AUTO, 1'b1, 1'b0, 16'h0000);
			check("auto low", 32'h0002, rdat);
			{hw, saw} = 2'b10;
			@(negedge clk);
			ds1_n = 1'b0;
			hold;
			check("auto high", 32'h5A5B, hd);
			ds1_n = 1'b1;
			@(negedge clk);
			cs_n = 1'b1;
			@(negedge clk);
			cs_n = 1'b0;
			saw = 1'b0;
			hold;
			check("busy", 32'h1, saw);
			acc(`SEL_DATA_FIXED, 1'b1, 1'b1, 16'h0000);
			check("prefetch", 32'h5A5C, rdat);
		end
	endtask
	task t_read;
		begin
			acc(`SEL_DATA_FIXED, 1'b1, 1'b0, 16'h0000);
			check("busy", 32'h1, saw);
			check("low half", 32'h0001, rdat);
			acc(`SEL_DATA_FIXED, 1'b1, 1'b1, 16'h0000);
			check("high half", 32'h5A5A, rdat);
			check("oe", 32'h0, oe);
		end
	endtask
	task t_write;
		begin
			stall = 1'b1;
			acc(`SEL_DATA_AUTO, 1'b0, 1'b0, 16'h1111);
			acc(`SEL_DATA_AUTO, 1'b0, 1'b1, 16'h2222);
			check("busy", 32'h1, saw);
			stall = 1'b0;
			repeat (4) @(negedge clk);
			check("word", 32'h2222_1111, lw);
		end
	endtask
	task finish_test;
		begin
			if (bad_count == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Watchdog far past the expected run
	initial begin
		#200000;
		bad_count = bad_count + 1;
		finish_test;
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_idle;
		t_regs;
		t_read;
		t_auto;
		t_write;
		finish_test;
	end
endmodule
